/* File: logic/plss_pkg.sv */
// Package for the panel line-sync shaper: register map, fields, reset values
`default_nettype none
package plss_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] PANEL_TIMING_ONE_OFFSET = 12'h400;
    localparam logic [31:0] PANEL_TIMING_ONE_RESET  = 32'h0000_0000;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int IN_POL_BIT     = 29;
    localparam int SRC_SEL_BIT    = 27;
    localparam int ROWS_MSB       = 26;
    localparam int ROWS_LSB       = 16;
    localparam int LEAD_MSB       = 7;
    localparam int LEAD_LSB       = 5;
    localparam int TRAIL_MSB      = 4;
    localparam int TRAIL_LSB      = 0;
    // Writable bits; reserved 31, 28 and 15:8 are dropped
    localparam logic [31:0] WRITE_MASK = 32'h6FFF_00FF;
    // Line-sync output polarity lives in the second timing register
    localparam logic [11:0] PANEL_TIMING_TWO_OFFSET = 12'h404;
    localparam int OUT_POL_BIT    = 22;
    // ------------------------------------------------------------------
    // Edge timing
    // ------------------------------------------------------------------
    localparam int LEAD_BASE_CLKS = 1;   // Code n>0 maps to n+1 clocks
    localparam int CNT_W          = 5;
    typedef enum logic [1:0] {
        PLSS_IDLE   = 2'b00,
        PLSS_WAIT   = 2'b01,
        PLSS_PULSE  = 2'b11
    } plss_state_t;
endpackage
`default_nettype wire

/* File: logic/plss_sync_if.sv */
// Interface carrying line-sync signals between shaper and edge generator
`timescale 1ns/1ps
`default_nettype none
interface plss_sync_if;
    logic                                startPulse;
    logic [2:0]                          leadCode;
    logic [4:0]                          trailCode;
    logic                                genActive;
    modport ctrl (output startPulse, output leadCode, output trailCode, input genActive);
    modport gen  (input startPulse, input leadCode, input trailCode, output genActive);
endinterface
`default_nettype wire

/* File: logic/plss_edge_gen.sv */
// Edge generator: counts pixel clocks from the modified sync rising edge
`timescale 1ns/1ps
`default_nettype none
module plss_edge_gen (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    plss_sync_if.gen  syncBus
);
    logic [plss_pkg::CNT_W-1:0] count;
    logic [plss_pkg::CNT_W-1:0] leadPos;
    plss_pkg::plss_state_t      state;

    // Lead code 0 means no delay; codes 1..7 give 2..8 clocks, never 1
    always_comb begin
        if (syncBus.leadCode == 3'h0) begin // [R6] [R7]
            leadPos = 5'h00;
        end else begin
            leadPos = 5'({2'h0, syncBus.leadCode}) + 5'(plss_pkg::LEAD_BASE_CLKS);
        end
    end

    // ------------------------------------------------------------------
    // Counter and state
    // ------------------------------------------------------------------
    // Restart on every rising edge of modified input
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            count <= 5'h00;
            state <= plss_pkg::PLSS_IDLE;
        end else if (syncBus.startPulse) begin // [R14]
            count <= 5'h01;
            state <= (leadPos == 5'h00) ? plss_pkg::PLSS_PULSE : plss_pkg::PLSS_WAIT;
        end else begin
            case (state)
                plss_pkg::PLSS_WAIT: begin
                    if (count == 5'h1F) begin
                        state <= plss_pkg::PLSS_IDLE;
                    end else if (count == leadPos) begin
                        state <= plss_pkg::PLSS_PULSE;
                    end
                    count <= count + 5'h01;
                end
                plss_pkg::PLSS_PULSE: begin
                    if (count == 5'h1F) begin
                        state <= plss_pkg::PLSS_IDLE;
                    end
                    count <= count + 5'h01;
                end
                default: begin
                    count <= count;
                end
            endcase
        end
    end

    // Active from lead position up to trail; empty pulse when trail <= lead
    always_comb begin
        syncBus.genActive = (state == plss_pkg::PLSS_PULSE) && !syncBus.startPulse
            && (syncBus.trailCode != 5'h00)                      // [R9]
            && (count <= syncBus.trailCode)                      // [R8]
            && (syncBus.trailCode > leadPos);                    // [R10]
    end
endmodule // plss_edge_gen
`default_nettype wire

/* File: logic/plss_panel_line_sync_shaper.sv */
// Panel line-sync shaper top: APB registers, input conditioning, output select
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: Polarity 0 means idle-low sync, 1 means idle-high sync.
// R2: Modified input is the incoming sync, inverted when polarity is 1.
// R3: Source select 0 passes the incoming sync straight to the pin.
// R4: Source select 1 regenerates sync, separate output polarity, edge fields.
// R5: Edge fields take effect only while internal generation is selected.
// R6: Lead code 000 gives no delay; 001..111 give 2..8 clocks.
// R7: No lead code gives a one-clock delay.
// R8: Trail code places trailing edge 1..31 clocks after rising edge.
// R9: Trail code zero produces no generated pulse; zero is default.
// R10: Zero or negative length pulses are suppressed entirely.
// R11: Software programs row count field with the panel line count.
// R12: Reserved bits 28 and 15:8 have no effect.
// R13: Register readable, writable, and cleared to zero on reset.
// R14: Counter restarts on each modified rising edge and times pulse.
module plss_panel_line_sync_shaper (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        input_line_sync,
    output logic             line_pulse_sync_pin,
    output logic [10:0]      panel_row_count
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] panelTimingOne;
    logic [31:0] panelTimingTwo;
    logic        syncMeta;
    logic        syncStable;
    logic        modifiedPrev;
    logic        modifiedSync;
    logic        sourceSel;
    logic        outPolarity;
    logic        apbWrite;
    logic        apbHitOne;
    logic        apbHitTwo;

    plss_sync_if syncBus ();

    // APB decode; one-cycle access phase with zero wait states
    assign apbWrite  = psel && penable && pwrite;
    assign apbHitOne = (paddr == plss_pkg::PANEL_TIMING_ONE_OFFSET);
    assign apbHitTwo = (paddr == plss_pkg::PANEL_TIMING_TWO_OFFSET);
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !apbHitOne && !apbHitTwo;

    // Timing register write; reserved bits stay zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            panelTimingOne <= plss_pkg::PANEL_TIMING_ONE_RESET; // [R13]
        end else if (apbWrite && apbHitOne) begin
            panelTimingOne <= pwdata & plss_pkg::WRITE_MASK;    // [R12] [R13]
        end
    end

    // Second timing register holds output polarity only here
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            panelTimingTwo <= 32'h0000_0000;
        end else if (apbWrite && apbHitTwo) begin
            panelTimingTwo <= pwdata & (32'h0000_0001 << plss_pkg::OUT_POL_BIT);
        end
    end

    // Read data registered; unmapped reads as zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (apbHitOne) begin
                prdata <= panelTimingOne; // [R13]
            end else if (apbHitTwo) begin
                prdata <= panelTimingTwo;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Row count field goes to the panel sequencer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            panel_row_count <= 11'h000;
        end else begin
            panel_row_count <= panelTimingOne[plss_pkg::ROWS_MSB:plss_pkg::ROWS_LSB]; // [R11]
        end
    end

    // ------------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------------
    // Two-flop synchroniser for the pin
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            syncMeta   <= 1'b0;
            syncStable <= 1'b0;
        end else begin
            syncMeta   <= input_line_sync;
            syncStable <= syncMeta;
        end
    end

    // Modified input: active-high view of the sync interval
    assign modifiedSync = syncStable ^ panelTimingOne[plss_pkg::IN_POL_BIT]; // [R1] [R2]

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            modifiedPrev <= 1'b0;
        end else begin
            modifiedPrev <= modifiedSync;
        end
    end

    assign sourceSel   = panelTimingOne[plss_pkg::SRC_SEL_BIT];
    assign outPolarity = panelTimingTwo[plss_pkg::OUT_POL_BIT];

    // Edge fields reach the generator only in internal mode
    assign syncBus.startPulse = modifiedSync && !modifiedPrev;           // [R14]
    assign syncBus.leadCode   = sourceSel ?
        panelTimingOne[plss_pkg::LEAD_MSB:plss_pkg::LEAD_LSB] : 3'h0;     // [R5]
    assign syncBus.trailCode  = sourceSel ?
        panelTimingOne[plss_pkg::TRAIL_MSB:plss_pkg::TRAIL_LSB] : 5'h00;  // [R5]

    plss_edge_gen u_edge_gen (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .syncBus (syncBus)
    );

    // ------------------------------------------------------------------
    // Output select
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            line_pulse_sync_pin <= 1'b0;
        end else if (sourceSel) begin
            line_pulse_sync_pin <= syncBus.genActive ^ outPolarity; // [R4]
        end else begin
            line_pulse_sync_pin <= syncStable;                      // [R3]
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_pass_through;
        @(posedge clk_sys) disable iff (!rst_n)
        (!sourceSel && $stable(sourceSel)) |=> (line_pulse_sync_pin == $past(syncStable));
    endproperty
    a_pass_through: assert property (p_pass_through) // [R3]
        else $error("pass-through output differs from input");

    property p_reset_zero;
        @(posedge clk_sys) !rst_n |=> (panelTimingOne == 32'h0000_0000);
    endproperty
    a_reset_zero: assert property (p_reset_zero) // [R13]
        else $error("timing register not cleared by reset");

    property p_reserved_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        (panelTimingOne[31] == 1'b0) && (panelTimingOne[28] == 1'b0)
            && (panelTimingOne[15:8] == 8'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // [R12]
        else $error("reserved bits set");

    property p_trail_zero_quiet;
        @(posedge clk_sys) disable iff (!rst_n)
        (syncBus.trailCode == 5'h00) |-> !syncBus.genActive;
    endproperty
    a_trail_zero_quiet: assert property (p_trail_zero_quiet) // [R9]
        else $error("pulse generated with zero trail code");

    property p_neg_len;
        @(posedge clk_sys) disable iff (!rst_n)
        sourceSel && (syncBus.trailCode <= u_edge_gen.leadPos)
            |=> (line_pulse_sync_pin == $past(outPolarity));
    endproperty
    a_neg_len: assert property (p_neg_len) // [R10]
        else $error("pulse generated with non-positive length");

    property p_lead_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        (syncBus.startPulse && sourceSel && syncBus.leadCode == 3'h0
            && syncBus.trailCode > 5'h01 && $stable(panelTimingOne))
        |=> syncBus.genActive;
    endproperty
    a_lead_zero: assert property (p_lead_zero) // [R6]
        else $error("no pulse right after rising edge with lead zero");

    property p_no_one_delay;
        @(posedge clk_sys) disable iff (!rst_n)
        (syncBus.startPulse && syncBus.leadCode != 3'h0) |=> !syncBus.genActive;
    endproperty
    a_no_one_delay: assert property (p_no_one_delay) // [R7]
        else $error("leading edge one clock after input edge");

    property p_modified;
        @(posedge clk_sys) disable iff (!rst_n)
        modifiedSync == (panelTimingOne[29] ? !syncStable : syncStable);
    endproperty
    a_modified: assert property (p_modified) // [R1] [R2]
        else $error("modified input polarity wrong");

    property p_restart;
        @(posedge clk_sys) disable iff (!rst_n)
        syncBus.startPulse |=> (u_edge_gen.count == 5'h01);
    endproperty
    a_restart: assert property (p_restart) // [R14]
        else $error("counter did not restart");

    // ------------------------------------------------------------------
    // Register bus checks
    // ------------------------------------------------------------------
    property p_write_lands;
        @(posedge clk_sys) disable iff (!rst_n)
        (apbWrite && apbHitOne)
            |=> (panelTimingOne == ($past(pwdata) & plss_pkg::WRITE_MASK));
    endproperty
    a_write_lands: assert property (p_write_lands) // [R13]
        else $error("timing register write lost");

    property p_read_data;
        @(posedge clk_sys) disable iff (!rst_n)
        (psel && !penable && !pwrite && apbHitOne)
            |=> (prdata == $past(panelTimingOne));
    endproperty
    a_read_data: assert property (p_read_data) // [R13]
        else $error("read data differs from timing register");

    property p_read_no_change;
        @(posedge clk_sys) disable iff (!rst_n)
        (psel && penable && !pwrite)
            |=> (panelTimingOne == $past(panelTimingOne));
    endproperty
    a_read_no_change: assert property (p_read_no_change) // [R13]
        else $error("read access changed timing register");

    property p_unmapped_ignored;
        @(posedge clk_sys) disable iff (!rst_n)
        (apbWrite && !apbHitOne)
            |=> (panelTimingOne == $past(panelTimingOne));
    endproperty
    a_unmapped_ignored: assert property (p_unmapped_ignored) // [R13]
        else $error("foreign write changed timing register");

    property p_unmapped_err;
        @(posedge clk_sys) disable iff (!rst_n)
        (psel && penable && !apbHitOne && !apbHitTwo) |-> pslverr;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("no error for unmapped access");

    property p_two_mask;
        @(posedge clk_sys) disable iff (!rst_n)
        (panelTimingTwo & ~(32'h0000_0001 << plss_pkg::OUT_POL_BIT)) == 32'h0000_0000;
    endproperty
    a_two_mask: assert property (p_two_mask)
        else $error("unused bits set in second timing register");

    property p_reset_out;
        @(posedge clk_sys) !rst_n |=> (line_pulse_sync_pin == 1'b0)
            && (panel_row_count == 11'h000) && (prdata == 32'h0000_0000);
    endproperty
    a_reset_out: assert property (p_reset_out) // [R13]
        else $error("outputs not cleared by reset");

    property p_row_copy;
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> (panel_row_count
            == $past(panelTimingOne[plss_pkg::ROWS_MSB:plss_pkg::ROWS_LSB]));
    endproperty
    a_row_copy: assert property (p_row_copy) // [R11]
        else $error("row count output differs from field");

    // ------------------------------------------------------------------
    // Line-sync checks
    // ------------------------------------------------------------------
    property p_sync_chain;
        @(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |-> (syncStable == $past(syncMeta));
    endproperty
    a_sync_chain: assert property (p_sync_chain) // [R2]
        else $error("synchroniser stage skipped");

    property p_rise_starts;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(modifiedSync) |-> syncBus.startPulse;
    endproperty
    a_rise_starts: assert property (p_rise_starts) // [R14]
        else $error("rising edge did not start generator");

    property p_gen_output;
        @(posedge clk_sys) disable iff (!rst_n)
        sourceSel |=> (line_pulse_sync_pin
            == ($past(syncBus.genActive) ^ $past(outPolarity)));
    endproperty
    a_gen_output: assert property (p_gen_output) // [R4]
        else $error("generated output or polarity wrong");

    property p_fields_ignored;
        @(posedge clk_sys) disable iff (!rst_n)
        !sourceSel |-> (syncBus.leadCode == 3'h0) && (syncBus.trailCode == 5'h00);
    endproperty
    a_fields_ignored: assert property (p_fields_ignored) // [R5]
        else $error("edge fields used in pass mode");

    property p_pass_quiet;
        @(posedge clk_sys) disable iff (!rst_n)
        !sourceSel |-> !syncBus.genActive;
    endproperty
    a_pass_quiet: assert property (p_pass_quiet) // [R5]
        else $error("generator active in pass mode");

    property p_lead_reach;
        @(posedge clk_sys) disable iff (!rst_n)
        (u_edge_gen.state == plss_pkg::PLSS_WAIT)
            && (u_edge_gen.count == u_edge_gen.leadPos)
            && (u_edge_gen.count != 5'h1F) && !syncBus.startPulse
            |=> (u_edge_gen.state == plss_pkg::PLSS_PULSE);
    endproperty
    a_lead_reach: assert property (p_lead_reach) // [R6]
        else $error("leading edge missed its position");

    property p_trail_end;
        @(posedge clk_sys) disable iff (!rst_n)
        syncBus.genActive && (u_edge_gen.count == syncBus.trailCode)
            |=> !syncBus.genActive || $changed(syncBus.trailCode);
    endproperty
    a_trail_end: assert property (p_trail_end) // [R8]
        else $error("pulse ran past trailing edge");

    property p_idle_quiet;
        @(posedge clk_sys) disable iff (!rst_n)
        (u_edge_gen.state == plss_pkg::PLSS_IDLE) |-> !syncBus.genActive;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) // [R14]
        else $error("pulse active while generator idle");
endmodule // plss_panel_line_sync_shaper
`default_nettype wire

/* File: tb/plss_line_source.sv */
// Model of the upstream line-sync source feeding the shaper
`timescale 1ns/1ps
`default_nettype none
module plss_line_source (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic en,
    input  wire logic pol,
    output logic      syncOut
);
    logic [5:0] phase;
    // Line period of 64 clocks, sync interval in the first 12
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !en) begin
            phase   <= 6'h00;
            syncOut <= pol; // Idle level follows polarity
        end else begin
            phase   <= phase + 6'h01;
            syncOut <= (phase < 6'h0C) ^ pol; // Sync interval is the inverse
        end
    end
endmodule // plss_line_source
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the panel line-sync shaper
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_sys, rst_n, psel, penable, pwrite, srcEn, inPol;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, syncIn, pin;
    logic [10:0] rowCnt;
    int          err_total, n_compared, refRise;
    // ------------------------------------------------------------------
    // Clock, instances
    // ------------------------------------------------------------------
    always #2 clk_sys = ~clk_sys;
    plss_panel_line_sync_shaper u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .input_line_sync(syncIn),
        .line_pulse_sync_pin(pin), .panel_row_count(rowCnt));
    plss_line_source u_src (.clk_sys(clk_sys), .rst_n(rst_n), .en(srcEn), .pol(inPol),
        .syncOut(syncIn));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic end_of_test();
        if (err_total == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    // One APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge clk_sys);
        psel <= 1'h1; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'h1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0; penable <= 1'h0;
    endtask
    // Program both timing registers with the source stopped
    task automatic setup(input logic sel, input logic ip, input logic op,
                         input logic [2:0] ld, input logic [4:0] tr);
        logic [31:0] d;
        logic        e;
        srcEn <= 1'h0;
        inPol <= ip;
        apb(1'h1, 12'h404, {9'h000, op, 22'h000000}, d, e);
        apb(1'h1, 12'h400, {2'h0, ip, 1'h0, sel, 11'h000, 8'h00, ld, tr}, d, e);
        repeat (64) @(posedge clk_sys);
        srcEn <= 1'h1;
    endtask
    // Cycles from modified input rise to active start and end of the pin
    task automatic measure(input logic op, output int rs, output int fl);
        logic pm, a;
        int   n;
        rs = -1;
        fl = -1;
        n = 0;
        @(posedge clk_sys);
        pm = syncIn ^ inPol;
        do begin
            @(posedge clk_sys);
            a = pm;
            pm = syncIn ^ inPol;
            n++;
        end while (!(a == 1'h0 && pm == 1'h1) && n < 200);
        for (n = 1; n <= 60; n++) begin
            @(posedge clk_sys);
            a = pin ^ op;
            if (a === 1'h1 && rs < 0) rs = n;
            if (a === 1'h0 && rs >= 0 && fl < 0) fl = n;
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] d;
        logic        e;
        cmp(32'h0, pin);
        apb(1'h0, 12'h400, 32'h0, d, e);
        cmp(plss_pkg::PANEL_TIMING_ONE_RESET, d);
        cmp(32'h0, rowCnt);
        apb(1'h1, 12'h400, 32'hFFFFFFFF, d, e);
        apb(1'h0, 12'h400, 32'h0, d, e);
        cmp(plss_pkg::WRITE_MASK, d);
        cmp(32'h7FF, rowCnt);
        apb(1'h1, 12'h400, 32'h01E00000, d, e);
        repeat (2) @(posedge clk_sys);
        cmp(32'h1E0, rowCnt);
        apb(1'h1, 12'h408, 32'hFFFFFFFF, d, e);
        cmp(32'h1, e);
        apb(1'h0, 12'h408, 32'h0, d, e);
        cmp(32'h1, e);
        cmp(32'h0, d);
        apb(1'h0, 12'h400, 32'h0, d, e);
        cmp(32'h01E00000, d);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk_sys);
        cmp(32'h0, pin);
        rst_n <= 1'h1;
        apb(1'h0, 12'h400, 32'h0, d, e);
        cmp(plss_pkg::PANEL_TIMING_ONE_RESET, d);
        cmp(32'h0, rowCnt);
    endtask
    task automatic t_pass(input logic ip, input logic op);
        int rs, fl;
        setup(1'h0, ip, op, 3'h7, 5'h03);
        measure(ip, rs, fl);
        cmp(32'd3, rs);
        cmp(32'd12, fl - rs);
    endtask
    task automatic t_gen(input logic ip, input logic op, input logic [2:0] ld,
                         input logic [4:0] tr);
        int rs, fl, lc;
        lc = (ld == 3'h0) ? 0 : ld + 1;
        setup(1'h1, ip, op, ld, tr);
        measure(op, rs, fl);
        if (ld == 3'h0 && tr == 5'h1F) refRise = rs;
        if (tr > lc) begin
            cmp(lc, rs - refRise);
            cmp(tr - lc, fl - rs);
        end else begin
            cmp(32'hFFFFFFFF, rs);
        end
    endtask
    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'h0; rst_n = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
        paddr = 12'h000; pwdata = 32'h0; srcEn = 1'h0; inPol = 1'h0;
        err_total = 0; n_compared = 0; refRise = 0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'h1;
        t_regs();
        t_pass(1'h0, 1'h0);
        t_pass(1'h1, 1'h1);
        t_gen(1'h0, 1'h0, 3'h0, 5'h1F);
        t_gen(1'h1, 1'h0, 3'h1, 5'h0A);
        t_gen(1'h0, 1'h1, 3'h7, 5'h1F);
        t_gen(1'h1, 1'h1, 3'h4, 5'h06);
        t_gen(1'h0, 1'h0, 3'h3, 5'h04);
        t_gen(1'h0, 1'h0, 3'h7, 5'h05);
        t_gen(1'h1, 1'h0, 3'h0, 5'h00);
        end_of_test();
    end
    initial begin
        #200000;
        err_total++;
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
